// File: verilog/ptmr_pkg.sv
// ptmr_pkg: constants for the 8-bit period timer with pwm time base
// assumes a wishbone classic slave with 32-bit data, byte lanes in sel
//
// Overview of operation
// - count wraps to zero after matching period
// - period loads all ones on reset
// - count clears on reset, software read/write
// - period is eight bits, always read/write
// - prescaler input is the instruction-rate tick
// - control 1:0 picks prescale 1, 4, 16
// - control 6:3 picks postscale 1 to 16
// - postscaler completion sets latched match flag
// - count/control write or reset clears scalers
// - control write leaves count unchanged
// - control bit 7 reads zero, others reset zero
// - raw match only feeds pwm time base
// - time base for pwm mode only
package ptmr_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] PTMR_OFS_CONTROL = 4'h0;
    localparam logic [3:0] PTMR_OFS_COUNT = 4'h4;
    localparam logic [3:0] PTMR_OFS_PERIOD = 4'h8;
    localparam logic [3:0] PTMR_OFS_STATUS = 4'hC;
    localparam logic [3:0] PTMR_ADDR_W = 4'h4;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PTMR_RUN_BIT = 2;
    localparam int PTMR_PRE_LSB = 0;
    localparam int PTMR_POST_LSB = 3;
    localparam int PTMR_FLAG_BIT = 0;
    localparam int PTMR_EN_BIT = 8;
    localparam logic [7:0] PTMR_CTRL_MASK = 8'h7F;
    localparam logic [7:0] PTMR_CTRL_RST = 8'h00;
    localparam logic [7:0] PTMR_COUNT_RST = 8'h00;
    localparam logic [7:0] PTMR_PERIOD_RST = 8'hFF;
    // ------------------------------------------------------------
    // timing: instruction clock is oscillator / 4
    // ------------------------------------------------------------
    localparam int PTMR_OSC_PER_INSTR = 4;
    localparam logic [1:0] PTMR_INSTR_DIV_LAST = 2'(PTMR_OSC_PER_INSTR - 1);
    localparam logic [3:0] PTMR_PRE1_LAST = 4'h0;
    localparam logic [3:0] PTMR_PRE4_LAST = 4'h3;
    localparam logic [3:0] PTMR_PRE16_LAST = 4'hF;
endpackage : ptmr_pkg

// File: verilog/ptmr_prescale.sv
// ptmr_prescale: divides the instruction-rate tick by 1, 4 or 16
// assumes tick_i is one cycle wide and clr_i may arrive at any time
`timescale 1ns/1ps
`default_nettype none
module ptmr_prescale (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    output logic pulse_o
);
    logic [3:0] cnt_r;
    logic [3:0] last;

    always_comb begin
        if (sel_i[1]) begin
            last = ptmr_pkg::PTMR_PRE16_LAST;
        end else if (sel_i[0]) begin
            last = ptmr_pkg::PTMR_PRE4_LAST;
        end else begin
            last = ptmr_pkg::PTMR_PRE1_LAST;
        end
    end

    assign pulse_o = tick_i && !clr_i && (cnt_r >= last);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= 4'h0;
        end else if (tick_i) begin
            cnt_r <= (cnt_r >= last) ? 4'h0 : cnt_r + 4'h1;
        end
    end
endmodule : ptmr_prescale
`default_nettype wire

// File: verilog/ptmr_postscale.sv
// ptmr_postscale: counts period matches, pulses after 1 to 16 of them
// assumes match_i is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module ptmr_postscale (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic match_i,
    input wire logic [3:0] sel_i,
    output logic done_o
);
    logic [3:0] cnt_r;

    assign done_o = match_i && !clr_i && (cnt_r >= sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= 4'h0;
        end else if (match_i) begin
            cnt_r <= (cnt_r >= sel_i) ? 4'h0 : cnt_r + 4'h1;
        end
    end
endmodule : ptmr_postscale
`default_nettype wire

// File: verilog/ptmr_timer.sv
// ptmr_timer: 8-bit period timer with prescaler, postscaler and irq
// assumes a wishbone classic master; clk_i is the oscillator clock
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ptmr_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    output logic pwm_base_o
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic [31:0] rd_data;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0];
    assign wr_ctrl = wr && (adr_i == ptmr_pkg::PTMR_OFS_CONTROL);
    assign wr_count = wr && (adr_i == ptmr_pkg::PTMR_OFS_COUNT);
    assign wr_period = wr && (adr_i == ptmr_pkg::PTMR_OFS_PERIOD);
    assign wr_status = wr && (adr_i == ptmr_pkg::PTMR_OFS_STATUS);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] count_r;
    logic [7:0] period_r;
    logic flag_r;
    logic en_r;
    logic [1:0] instr_div_r;
    logic instr_tick;
    logic scaler_clr;
    logic pre_pulse;
    logic match;
    logic post_done;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= ptmr_pkg::PTMR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= dat_i[7:0] & ptmr_pkg::PTMR_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_r <= ptmr_pkg::PTMR_PERIOD_RST;
        end else if (wr_period) begin
            period_r <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // instruction clock: oscillator / 4, free running
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end

    // prescaler sees instruction ticks only while running
    assign instr_tick = (instr_div_r == ptmr_pkg::PTMR_INSTR_DIV_LAST)
        && ctrl_r[ptmr_pkg::PTMR_RUN_BIT];
    assign scaler_clr = wr_ctrl || wr_count;

    ptmr_prescale u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(scaler_clr),
        .tick_i(instr_tick),
        .sel_i(ctrl_r[ptmr_pkg::PTMR_PRE_LSB +: 2]),
        .pulse_o(pre_pulse)
    );

    assign match = pre_pulse && (count_r == period_r);

    // ------------------------------------------------------------
    // count: a control write never touches it
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= ptmr_pkg::PTMR_COUNT_RST;
        end else if (wr_count) begin
            count_r <= dat_i[7:0];
        end else if (match) begin
            count_r <= ptmr_pkg::PTMR_COUNT_RST;
        end else if (pre_pulse) begin
            count_r <= count_r + 8'h01;
        end
    end

    ptmr_postscale u_post (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(scaler_clr),
        .match_i(match),
        .sel_i(ctrl_r[ptmr_pkg::PTMR_POST_LSB +: 4]),
        .done_o(post_done)
    );

    // ------------------------------------------------------------
    // interrupt: sticky flag, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else if (post_done) begin
            flag_r <= 1'b1;
        end else if (wr_status && dat_i[ptmr_pkg::PTMR_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 1'b0;
        end else if (wr_status && sel_i[1]) begin
            en_r <= dat_i[ptmr_pkg::PTMR_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (flag_r || post_done) && en_r;
        end
    end

    // raw match, registered; pwm units only, never a serial clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_base_o <= 1'b0;
        end else begin
            pwm_base_o <= match;
        end
    end

    // ------------------------------------------------------------
    // read mux and ack
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        case (adr_i)
            ptmr_pkg::PTMR_OFS_CONTROL: rd_data[7:0] = ctrl_r;
            ptmr_pkg::PTMR_OFS_COUNT: rd_data[7:0] = count_r;
            ptmr_pkg::PTMR_OFS_PERIOD: rd_data[7:0] = period_r;
            ptmr_pkg::PTMR_OFS_STATUS: begin
                rd_data[ptmr_pkg::PTMR_FLAG_BIT] = flag_r;
                rd_data[ptmr_pkg::PTMR_EN_BIT] = en_r;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_data : 32'h0000_0000;
        end
    end
endmodule : ptmr_timer
`default_nettype wire

// File: tb/ptmr_pwm_model.sv
// ptmr_pwm_model: pwm-mode consumer of the timer's raw match pulse
// assumes base_i is a one-cycle pulse on clk_i
`timescale 1ns/1ps
`default_nettype none
module ptmr_pwm_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic base_i,
    output int pulses_o,
    output int gap_o
);
    int since;
    // only the time base is taken; no capture or compare use here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulses_o <= 0;
            gap_o <= 0;
            since <= 0;
        end else if (base_i) begin
            pulses_o <= pulses_o + 1;
            gap_o <= since + 1;
            since <= 0;
        end else begin
            since <= since + 1;
        end
    end
endmodule : ptmr_pwm_model
`default_nettype wire

// File: tb/ptmr_timer_monitor.sv
// ptmr_timer_monitor: port-level assertions for ptmr_timer
// assumes one clock clk_i and synchronous reset rst_i
`timescale 1ns/1ps
`default_nettype none
module ptmr_timer_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o,
    input wire logic pwm_base_o
);
    logic st_wr;
    assign st_wr = cyc_i & stb_i & we_i & (adr_i == ptmr_pkg::PTMR_OFS_STATUS);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("data without ack");
    chk_ctrl_top: assert property (ack_o && !$past(we_i)
        && $past(adr_i) == ptmr_pkg::PTMR_OFS_CONTROL |-> dat_o[31:7] == 25'h000_0000)
        else $error("control top bits set");
    chk_rst_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !irq_o && !pwm_base_o) else $error("outputs live in reset");
    // matches only on instruction ticks, so never closer than four clocks
    chk_base_gap: assert property (pwm_base_o |=> !pwm_base_o [*3])
        else $error("match pulses too close");
    chk_irq_cause: assert property ($rose(irq_o) |-> pwm_base_o || $past(pwm_base_o)
        || $past(pwm_base_o, 2) || $past(st_wr) || $past(st_wr, 2))
        else $error("irq without cause");
    chk_irq_hold: assert property ($fell(irq_o) |-> $past(st_wr) || $past(st_wr, 2))
        else $error("irq dropped alone");
endmodule : ptmr_timer_monitor
bind ptmr_timer ptmr_timer_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .pwm_base_o(pwm_base_o));
`default_nettype wire

// File: tb/ptmr_timer_tb_top.sv
// ptmr_timer_tb_top: directed bench for the period timer
// assumes the pwm model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin error_cnt++; \
    $display("BAD %s exp %h saw %h", n, e, s); end end
module ptmr_timer_tb_top;
    logic clk_i, rst_i, cyc, stb, we, ack_o, irq_o, base;
    logic [3:0] adr, sel;
    logic [31:0] wdat, dat_o, q;
    int error_cnt, check_count, cycles, pulses, gap;
    ptmr_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .pwm_base_o(base));
    ptmr_pwm_model u_pwm (.clk_i(clk_i), .rst_i(rst_i), .base_i(base), .pulses_o(pulses),
        .gap_o(gap));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ----------------------------------------
    // bus and wait helpers
    // ----------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] b);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= b;
        // no local limit: only the cycle watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // k pulses (three in t_rate), so the judged gap never spans a configuration change
    task automatic wait_p(input int k);
        int p;
        p = pulses;
        while (pulses < p + k) begin
            @(posedge clk_i);
        end
    endtask : wait_p
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] rv [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000};
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 4'(i * 4), 32'h0000_0000, 4'hF);
            `CHK("reset value", rv[i], q)
        end
    endtask : t_regs
    task automatic t_access();
        wb(1'b1, 4'h8, 32'h0000_00A5, 4'hF);
        wb(1'b1, 4'h8, 32'h0000_005A, 4'h0);
        wb(1'b0, 4'h8, 32'h0000_0000, 4'hF);
        `CHK("period", 32'h0000_00A5, q)
        wb(1'b1, 4'h0, 32'hFFFF_FFFB, 4'hF);
        wb(1'b0, 4'h0, 32'h0000_0000, 4'hF);
        `CHK("control", 32'h0000_007B, q)
        wb(1'b1, 4'h2, 32'h0000_00FF, 4'hF);
        wb(1'b0, 4'h2, 32'h0000_0000, 4'hF);
        `CHK("unmapped", 32'h0000_0000, q)
        wb(1'b1, 4'h4, 32'h0000_0033, 4'hF);
        // prescale 1 while stopped, so a leaky run gate would show within 50 clocks
        wb(1'b1, 4'h0, 32'h0000_0000, 4'hF);
        repeat (50) @(posedge clk_i);
        wb(1'b0, 4'h4, 32'h0000_0000, 4'hF);
        `CHK("held count", 32'h0000_0033, q)
    endtask : t_access
    task automatic t_rate();
        int dv [4] = '{1, 4, 16, 16};
        wb(1'b1, 4'h8, 32'h0000_0001, 4'hF);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 4'h4, 32'h0000_0000, 4'hF);
            wb(1'b1, 4'h0, 32'h0000_0004 | 32'(i), 4'hF);
            wait_p(3);
            `CHK("match gap", 8 * dv[i], gap)
        end
    endtask : t_rate
    task automatic t_post();
        int sv [3] = '{0, 1, 15};
        int p;
        // short period after reset, so sixteen matches stay well inside the watchdog
        wb(1'b1, 4'h8, 32'h0000_0001, 4'hF);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, 4'h0, 32'h0000_0000, 4'hF);
            wb(1'b1, 4'h4, 32'h0000_0000, 4'hF);
            wb(1'b1, 4'hC, 32'h0000_0101, 4'hF);
            p = pulses;
            wb(1'b1, 4'h0, 32'(sv[i] << 3) | 32'h0000_0004, 4'hF);
            while (irq_o !== 1'b1) begin
                @(posedge clk_i);
            end
            @(posedge clk_i);
            `CHK("matches per flag", sv[i] + 1, pulses - p)
        end
        wb(1'b1, 4'h0, 32'h0000_0000, 4'hF);
        wb(1'b1, 4'hC, 32'h0000_0000, 4'hF);
        `CHK("masked irq", 1'b0, irq_o)
        wb(1'b0, 4'hC, 32'h0000_0000, 4'hF);
        `CHK("sticky flag", 32'h0000_0001, q)
        wb(1'b1, 4'hC, 32'h0000_0001, 4'hF);
        wb(1'b0, 4'hC, 32'h0000_0000, 4'hF);
        `CHK("flag cleared", 32'h0000_0000, q)
    endtask : t_post
    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        {error_cnt, check_count, cycles} = '0;
        {cyc, stb, we, adr, sel, wdat} = '0;
        do_reset();
        t_regs();
        t_access();
        t_rate();
        do_reset();
        t_regs();
        t_post();
        finish_test();
    end
endmodule : ptmr_timer_tb_top
`default_nettype wire
